// >>> verilog/bdcc_top.sv
/*
  bdcc_top: calendar clock unit with alarms, wakeup timer, calibration
  output and backup data registers.
  assumes: ls_clk_pin is a 32.768 kHz level from a pin, much slower than clk;
  software uses the plain register port; backup words are reset only by
  power-on of their own domain, never by rst.
*/
// The register addresses and the strobed register port were decided locally.
// Functional notes
// - seconds to year are kept in BCD, hours in 12 or 24 hour form.
// - a binary sub-second count runs below the seconds.
// - months wrap after 28, 29, 30 or 31 days, leap Februaries hold 29.
// - alarms and wakeup raise the interrupt and the low-power wake line.
// - a 512 Hz square wave can be driven out for calibration.
// - two alarms compare hours, minutes and seconds, each field with its own mask.
// - a 16-bit reload downcounter gives periodic wakeup events.
// - a programmable prescaler gives 1 s from 32.768 kHz at reset.
// - twenty 32-bit backup words can be read and written.
// - backup words survive system reset, power reset and standby exit.
`timescale 1ns/1ns
module bdcc_top
  import bdcc_pkg::*;
#(
  parameter int BKP_WORDS = BDCC_BKP_WORDS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // low-speed clock pin
  input  wire logic        ls_clk_pin,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // events
  output logic             irq,
  output logic             wake,
  output logic             cal_out,
  output logic             cal_oe
);

  // ********************************************************
  // low-speed clock edge, synchronised
  // ********************************************************
  logic [2:0] ls_sync_q;
  logic       ls_tick;

  // two stages then an edge detector on stage two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ls_sync_q <= 3'h0;
    end else begin
      ls_sync_q <= {ls_sync_q[1:0], ls_clk_pin};
    end
  end
  assign ls_tick = ls_sync_q[1] & ~ls_sync_q[2];

  // ********************************************************
  // registers
  // ********************************************************
  logic [BDCC_CTRL_WIDTH-1:0] ctrl_q;
  logic [6:0]                 apre_q;
  logic [14:0]                spre_q;
  logic [15:0]                wake_rld_q;
  logic [31:0]                ala_q;
  logic [31:0]                alb_q;
  logic [BDCC_ST_W-1:0]       sts_q;
  logic [BDCC_ST_W-1:0]       mask_q;
  bdcc_time_t                 time_q;
  bdcc_date_t                 date_q;
  logic [31:0]                bkp_q [BKP_WORDS];

  // control, prescaler, wakeup, alarm, mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q     <= '0;
      apre_q     <= BDCC_APRE_RST;
      spre_q     <= BDCC_SPRE_RST;
      wake_rld_q <= BDCC_WAKE_RST;
      ala_q      <= 32'h0;
      alb_q      <= 32'h0;
      mask_q     <= '0;
    end else if (wr) begin
      unique case (addr)
        BDCC_OFS_CTRL:  ctrl_q     <= wdata[BDCC_CTRL_WIDTH-1:0];
        BDCC_OFS_PRESC: begin
          apre_q <= wdata[22:16];
          spre_q <= wdata[14:0];
        end
        BDCC_OFS_WAKE:  wake_rld_q <= wdata[15:0];
        BDCC_OFS_ALA:   ala_q      <= wdata;
        BDCC_OFS_ALB:   alb_q      <= wdata;
        BDCC_OFS_MASK:  mask_q     <= wdata[BDCC_ST_W-1:0];
        default: ;
      endcase
    end
  end

  // backup words: no rst, they live across system resets
  always_ff @(posedge clk) begin
    for (int i = 0; i < BKP_WORDS; i++) begin
      if (wr && addr == BDCC_OFS_BKP + 8'(4 * i)) begin
        bkp_q[i] <= wdata;
      end
    end
  end

  // ********************************************************
  // prescalers
  // ********************************************************
  logic [6:0]  acnt_q;
  logic [14:0] scnt_q;
  logic        ck_apre;
  logic        sec_tick;
  logic        run;

  assign run      = ctrl_q[BDCC_CTRL_EN];
  assign ck_apre  = run & ls_tick & (acnt_q == 7'h00);
  assign sec_tick = ck_apre & (scnt_q == 15'h0000);

  // asynchronous then synchronous divide, both downcount
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acnt_q <= BDCC_APRE_RST;
      scnt_q <= BDCC_SPRE_RST;
    end else if (!run) begin
      acnt_q <= apre_q;
      scnt_q <= spre_q;
    end else if (ls_tick) begin
      acnt_q <= (acnt_q == 7'h00) ? apre_q : acnt_q - 7'h01;
      if (ck_apre) begin
        scnt_q <= sec_tick ? spre_q : scnt_q - 15'h0001;
      end
    end
  end

  // ********************************************************
  // calendar
  // ********************************************************
  logic [7:0] sec_n, min_n, hr_n, day_n, mon_n, yr_n;
  logic       sec_w, min_w, hr_w, day_w, mon_w;
  logic [7:0] hr_lo, hr_hi, day_hi;
  logic       leap;
  logic       h12;

  assign h12   = ctrl_q[BDCC_CTRL_H12];
  assign hr_lo = h12 ? 8'h01 : 8'h00;
  assign hr_hi = h12 ? 8'h12 : 8'h23;
  // bcd year divisible by four
  assign leap  = (date_q.year[4] == 1'b0) ? (date_q.year[3:0] == 4'h0 ||
                  date_q.year[3:0] == 4'h4 || date_q.year[3:0] == 4'h8)
                : (date_q.year[3:0] == 4'h2 || date_q.year[3:0] == 4'h6);

  // month length
  always_comb begin
    unique case (date_q.month)
      5'h02:                      day_hi = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: day_hi = 8'h30;
      default:                    day_hi = 8'h31;
    endcase
  end

  bdcc_bcd_cnt u_sec (.val({1'b0, time_q.sec}), .lo(8'h00), .hi(8'h59),
                      .nxt(sec_n), .wrap(sec_w));
  bdcc_bcd_cnt u_min (.val({1'b0, time_q.min}), .lo(8'h00), .hi(8'h59),
                      .nxt(min_n), .wrap(min_w));
  bdcc_bcd_cnt u_hr  (.val({2'b00, time_q.hour}), .lo(hr_lo), .hi(hr_hi),
                      .nxt(hr_n), .wrap(hr_w));
  bdcc_bcd_cnt u_day (.val({2'b00, date_q.day}), .lo(8'h01), .hi(day_hi),
                      .nxt(day_n), .wrap(day_w));
  bdcc_bcd_cnt u_mon (.val({3'b000, date_q.month}), .lo(8'h01), .hi(8'h12),
                      .nxt(mon_n), .wrap(mon_w));
  bdcc_bcd_cnt u_yr  (.val(date_q.year), .lo(8'h00), .hi(8'h99),
                      .nxt(yr_n), .wrap());

  logic day_step;
  // 12-hour day ends going 11 pm to 12 am; 24-hour at 23 to 00
  assign day_step = h12 ? (time_q.hour == 6'h11 && time_q.pm) : hr_w;

  // time fields; software writes load them directly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      time_q <= '0;
    end else if (wr && addr == BDCC_OFS_TIME) begin
      time_q <= bdcc_time_t'(wdata[20:0]);
    end else if (sec_tick) begin
      time_q.sec <= sec_n[6:0];
      if (sec_w) begin
        time_q.min <= min_n[6:0];
        if (min_w) begin
          time_q.hour <= hr_n[5:0];
          if (h12 && time_q.hour == 6'h11) begin
            time_q.pm <= ~time_q.pm;
          end
        end
      end
    end
  end

  // date fields and weekday
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      date_q <= '{year: 8'h00, wday: 3'h1, month: 5'h01, day: 6'h01};
    end else if (wr && addr == BDCC_OFS_DATE) begin
      date_q <= bdcc_date_t'(wdata[21:0]);
    end else if (sec_tick && sec_w && min_w && day_step) begin
      date_q.day  <= day_n[5:0];
      date_q.wday <= (date_q.wday == 3'h7) ? 3'h1 : date_q.wday + 3'h1;
      if (day_w) begin
        date_q.month <= mon_n[4:0];
        if (mon_w) begin
          date_q.year <= yr_n;
        end
      end
    end
  end

  // ********************************************************
  // alarms: bits 27..24 field masks, 21..0 hour/min/sec bcd, day bits 23..22 match only 00
  // ********************************************************
  logic [1:0] al_hit;
  logic [1:0] al_en;
  assign al_en = {ctrl_q[BDCC_CTRL_ALBE], ctrl_q[BDCC_CTRL_ALAE]};

  // one comparator per alarm; a masked field always matches
  for (genvar g = 0; g < 2; g++) begin : g_alarm
    logic [31:0] a;
    assign a = (g == 0) ? ala_q : alb_q;
    assign al_hit[g] = al_en[g] & sec_tick &
      (a[24] | (a[6:0]   == sec_n[6:0])) &
      (a[25] | (a[14:8]  == (sec_w ? min_n[6:0] : time_q.min))) &
      (a[26] | (a[21:16] == time_q.hour)) &
      (a[27] | (a[23:22] == 2'b00));
  end

  // ********************************************************
  // wakeup downcounter
  // ********************************************************
  logic [15:0] wcnt_q;
  logic [3:0]  wdiv_q;
  logic        wk_clk;
  logic        wk_hit;

  // resolution: ls/2, ls/4, ls/8 or ls/16
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdiv_q <= 4'h0;
    end else if (ls_tick) begin
      wdiv_q <= wdiv_q + 4'h1;
    end
  end
  always_comb begin
    unique case (ctrl_q[BDCC_CTRL_WKSEL +: 2])
      2'h0:    wk_clk = ls_tick & wdiv_q[0];
      2'h1:    wk_clk = ls_tick & (wdiv_q[1:0] == 2'h3);
      2'h2:    wk_clk = ls_tick & (wdiv_q[2:0] == 3'h7);
      default: wk_clk = ls_tick & (wdiv_q == 4'hF);
    endcase
  end
  assign wk_hit = ctrl_q[BDCC_CTRL_WKE] & wk_clk & (wcnt_q == 16'h0000);

  // reload on expiry
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wcnt_q <= BDCC_WAKE_RST;
    end else if (!ctrl_q[BDCC_CTRL_WKE]) begin
      wcnt_q <= wake_rld_q;
    end else if (wk_clk) begin
      wcnt_q <= wk_hit ? wake_rld_q : wcnt_q - 16'h0001;
    end
  end

  // ********************************************************
  // status, interrupt and wake
  // ********************************************************
  logic [BDCC_ST_W-1:0] ev;
  logic                 sts_rd;
  assign ev     = {wk_hit, al_hit[1], al_hit[0]};
  assign sts_rd = rd && addr == BDCC_OFS_STS;

  // sticky; a new event wins over the read clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sts_q <= '0;
    end else begin
      sts_q <= (sts_rd ? '0 : sts_q) | ev;
    end
  end
  assign irq  = |(sts_q & mask_q);
  assign wake = |sts_q;

  // ********************************************************
  // 512 Hz calibration output
  // ********************************************************
  logic [4:0] cdiv_q;
  logic       cal_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cdiv_q <= 5'h00;
      cal_q  <= 1'b0;
    end else if (ls_tick) begin
      if (cdiv_q == 5'(BDCC_CAL_DIV - 1)) begin
        cdiv_q <= 5'h00;
        cal_q  <= ~cal_q;
      end else begin
        cdiv_q <= cdiv_q + 5'h01;
      end
    end
  end
  assign cal_out = cal_q & ctrl_q[BDCC_CTRL_CALOE];
  assign cal_oe  = ctrl_q[BDCC_CTRL_CALOE];

  // ********************************************************
  // read data, one cycle after rd
  // ********************************************************
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0;
    unique case (addr)
      BDCC_OFS_TIME:   rmux = {11'h0, time_q};
      BDCC_OFS_DATE:   rmux = {10'h0, date_q};
      BDCC_OFS_CTRL:   rmux = {22'h0, ctrl_q};
      BDCC_OFS_PRESC:  rmux = {9'h0, apre_q, 1'b0, spre_q};
      BDCC_OFS_WAKE:   rmux = {wcnt_q, wake_rld_q};
      BDCC_OFS_ALA:    rmux = ala_q;
      BDCC_OFS_ALB:    rmux = alb_q;
      BDCC_OFS_SUBSEC: rmux = {17'h0, scnt_q};
      BDCC_OFS_STS:    rmux = {29'h0, sts_q};
      BDCC_OFS_MASK:   rmux = {29'h0, mask_q};
      default: begin
        for (int i = 0; i < BKP_WORDS; i++) begin
          if (addr == BDCC_OFS_BKP + 8'(4 * i)) begin
            rmux = bkp_q[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (rd) begin
      rdata <= rmux;
    end else begin
      rdata <= 32'h0;
    end
  end

endmodule

// >>> pkg/bdcc_pkg.sv
/*
  bdcc_pkg: register map, field layouts, reset values and timing counts of the
  battery domain calendar clock.
  assumes: one 10 MHz system clock; low-speed clock arrives as a pin input.
*/
package bdcc_pkg;

  // ********************************************************
  // register offsets (byte addresses, 32-bit words)
  // ********************************************************
  localparam logic [7:0] BDCC_OFS_TIME   = 8'h00;
  localparam logic [7:0] BDCC_OFS_DATE   = 8'h04;
  localparam logic [7:0] BDCC_OFS_CTRL   = 8'h08;
  localparam logic [7:0] BDCC_OFS_PRESC  = 8'h0C;
  localparam logic [7:0] BDCC_OFS_WAKE   = 8'h10;
  localparam logic [7:0] BDCC_OFS_ALA    = 8'h14;
  localparam logic [7:0] BDCC_OFS_ALB    = 8'h18;
  localparam logic [7:0] BDCC_OFS_SUBSEC = 8'h1C;
  localparam logic [7:0] BDCC_OFS_STS    = 8'h20;
  localparam logic [7:0] BDCC_OFS_MASK   = 8'h24;
  localparam logic [7:0] BDCC_OFS_BKP    = 8'h40;

  // ********************************************************
  // control register fields
  // ********************************************************
  localparam int BDCC_CTRL_EN     = 0;
  localparam int BDCC_CTRL_H12    = 1;
  localparam int BDCC_CTRL_ALAE   = 2;
  localparam int BDCC_CTRL_ALBE   = 3;
  localparam int BDCC_CTRL_WKE    = 4;
  localparam int BDCC_CTRL_CALOE  = 5;
  localparam int BDCC_CTRL_WKSEL  = 8;   // 2-bit wakeup clock select
  localparam int BDCC_CTRL_WIDTH  = 10;

  // ********************************************************
  // status bits
  // ********************************************************
  localparam int BDCC_ST_ALA  = 0;
  localparam int BDCC_ST_ALB  = 1;
  localparam int BDCC_ST_WK   = 2;
  localparam int BDCC_ST_W    = 3;

  // ********************************************************
  // reset values and counts
  // ********************************************************
  localparam logic [6:0]  BDCC_APRE_RST  = 7'h7F;    // 128 divide
  localparam logic [14:0] BDCC_SPRE_RST  = 15'h00FF; // 256 divide
  localparam logic [15:0] BDCC_WAKE_RST  = 16'hFFFF;
  localparam int          BDCC_LS_HZ     = 32768;
  localparam int          BDCC_CAL_HZ    = 512;
  localparam int          BDCC_CAL_DIV   = BDCC_LS_HZ / BDCC_CAL_HZ / 2;
  localparam int          BDCC_BKP_WORDS = 20;

  // calendar fields, all BCD
  typedef struct packed {
    logic       pm;
    logic [5:0] hour;
    logic [6:0] min;
    logic [6:0] sec;
  } bdcc_time_t;

  typedef struct packed {
    logic [7:0] year;
    logic [2:0] wday;
    logic [4:0] month;
    logic [5:0] day;
  } bdcc_date_t;

endpackage

// >>> verilog/bdcc_bcd_cnt.sv
/*
  bdcc_bcd_cnt: one two-digit BCD increment with wrap.
  assumes: value holds legal BCD; purely combinational.
*/
`timescale 1ns/1ns
module bdcc_bcd_cnt
  import bdcc_pkg::*;
(
  // value in
  input  wire logic [7:0] val,
  input  wire logic [7:0] lo,
  input  wire logic [7:0] hi,
  // value out
  output logic      [7:0] nxt,
  output logic            wrap
);

  // ********************************************************
  // increment
  // ********************************************************
  // bcd add one, back to lo after hi
  always_comb begin
    wrap = (val == hi);
    if (wrap) begin
      nxt = lo;
    end else if (val[3:0] == 4'h9) begin
      nxt = {val[7:4] + 4'h1, 4'h0};
    end else begin
      nxt = {val[7:4], val[3:0] + 4'h1};
    end
  end

endmodule

// >>> tb/bdcc_ls_src.sv
/*
  bdcc_ls_src: free-running low-speed clock as seen at the pin.
  assumes: scaled to HALF_NS per half period so runs stay short.
*/
`timescale 1ns/1ns
module bdcc_ls_src #(
  parameter int HALF_NS = 500
) (
  // low-speed clock out
  output logic ls_clk
);
  // the crystal runs free from a phase unrelated to clk
  initial begin
    ls_clk = 1'h0;
    #137;
    forever begin
      #HALF_NS ls_clk = ~ls_clk;
    end
  end
endmodule

// >>> tb/bdcc_properties.sv
/*
  bdcc_properties: port checks of the calendar clock top.
  assumes: bound to bdcc_top; one clock, rst async active high.
*/
`timescale 1ns/1ns
module bdcc_properties
  import bdcc_pkg::*;
#(
  parameter int BKP_WORDS = BDCC_BKP_WORDS
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // low-speed pin
  input wire logic        ls_clk_pin,
  // register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // events
  input wire logic        irq,
  input wire logic        wake,
  input wire logic        cal_out,
  input wire logic        cal_oe
);
  localparam logic [7:0] GAP = 8'(BDCC_OFS_BKP + 4 * BKP_WORDS);
  logic       ls_q;
  logic [3:0] since_q;

  // cycles since the last sampled low-speed rise, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ls_q    <= 1'h0;
      since_q <= 4'hF;
    end else begin
      ls_q <= ls_clk_pin;
      if (ls_clk_pin && !ls_q) begin
        since_q <= 4'h0;
      end else if (since_q != 4'hF) begin
        since_q <= since_q + 4'h1;
      end
    end
  end

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  a_rdata_quiet: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_gap_zero: assert property (rd && addr == GAP |=> rdata == 32'h0)
    else $error("word past the backup area not zero");
  a_bkp_readback: assert property (wr && addr == BDCC_OFS_BKP ##1
    rd && addr == BDCC_OFS_BKP |=> rdata == $past(wdata, 2))
    else $error("backup word not read back");
  a_irq_wake: assert property (irq |-> wake)
    else $error("interrupt without wake request");
  a_wake_holds: assert property (wake && !(rd && addr == BDCC_OFS_STS) |=> wake)
    else $error("wake dropped without status read");
  a_wake_clears: assert property ($fell(wake) |-> $past(rd && addr == BDCC_OFS_STS))
    else $error("wake fell without status read");
  a_irq_cause: assert property ($fell(irq) |-> $past(rd && addr == BDCC_OFS_STS)
    || $past(wr && addr == BDCC_OFS_MASK))
    else $error("interrupt fell without read or mask write");
  a_event_tick: assert property ($rose(wake) |-> since_q <= 4'h6)
    else $error("event not tied to a low-speed tick");
  a_cal_gated: assert property (!cal_oe |-> !cal_out)
    else $error("calibration output active while disabled");
  a_cal_tick: assert property (cal_oe && $past(cal_oe) && $changed(cal_out)
    |-> since_q <= 4'h6)
    else $error("calibration edge not on a low-speed tick");
  a_cal_write: assert property (wr && addr == BDCC_OFS_CTRL
    |=> cal_oe == $past(wdata[BDCC_CTRL_CALOE]))
    else $error("calibration enable not taken from control write");

  // main scenarios reached
  c_status: cover property (rd && addr == BDCC_OFS_STS ##1 rdata != 32'h0);
  c_cal: cover property ($rose(cal_out));
  c_irq: cover property ($rose(irq));
endmodule

bind bdcc_top bdcc_properties #(.BKP_WORDS(BKP_WORDS)) u_props (
  .clk(clk), .rst(rst), .ls_clk_pin(ls_clk_pin), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .wake(wake), .cal_out(cal_out),
  .cal_oe(cal_oe)
);

// >>> tb/test_bdcc_top.sv
/*
  test_bdcc_top: register-level bench for the calendar clock top.
  assumes: low-speed source at 10 clk per period; software shortens
  the prescaler to two low-speed periods per second.
*/
`timescale 1ns/1ns
module test_bdcc_top
  import bdcc_pkg::*;
;
  localparam int          LS_CLK = 10;
  localparam int          LIMIT  = 20000;
  localparam logic [31:0] T_LATE = 32'h0008_ECD9; // 23:59:59
  localparam logic [31:0] T_11   = 32'h0004_6CD9; // 11:59:59 am
  localparam logic [31:0] T_12PM = 32'h0014_8000; // 12:00:00 pm
  logic        clk, rst, ls_pin, wr, rd, irq, wake, cal_out, cal_oe;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, v;
  int          err_total, comparisons, cyc, t0;

  bdcc_top dut (
    .clk(clk), .rst(rst), .ls_clk_pin(ls_pin), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .wake(wake),
    .cal_out(cal_out), .cal_oe(cal_oe)
  );
  bdcc_ls_src u_ls (
    .ls_clk(ls_pin)
  );

  // 10 MHz clock, cycle count and hang guard
  initial clk = 1'h0;
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      finish_test();
    end
  end

  function automatic logic [31:0] dt(logic [7:0] y, logic [2:0] w, logic [4:0] m,
                                     logic [5:0] d);
    return {10'h0, y, w, m, d};
  endfunction
  function automatic logic [31:0] bk(int i);
    return 32'hA5C3_0F00 ^ (32'(i) * 32'h0001_0101);
  endfunction

  // one bus cycle: all signals set right after an edge, held to the next
  task automatic bus(input logic w, input logic r, input logic [7:0] a,
                     input logic [31:0] d);
    wr    <= w;
    rd    <= r;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, 1'h0, a, d);
    bus(1'h0, 1'h0, a, d);
  endtask
  task automatic rd32(input logic [7:0] a, output logic [31:0] d);
    bus(1'h0, 1'h1, a, 32'h0);
    bus(1'h0, 1'h0, a, 32'h0);
    d = rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic do_reset;
    rst <= 1'h1;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'h1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic wait_cal;
    logic o;
    int   n;
    o = cal_out;
    n = 0;
    while (cal_out === o && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic bkp_all;
    for (int i = 0; i < BDCC_BKP_WORDS; i++) begin
      rd32(8'(BDCC_OFS_BKP + 4 * i), v);
      chk(v, bk(i));
    end
  endtask
  // load a time and date stopped, run until the seconds move, compare
  task automatic roll(input logic [31:0] c, ti, di, tn, dn);
    int n;
    wr32(BDCC_OFS_CTRL, 32'h0);
    wr32(BDCC_OFS_TIME, ti);
    wr32(BDCC_OFS_DATE, di);
    wr32(BDCC_OFS_CTRL, c);
    n = 0;
    v = ti;
    while (v === ti && n < 60) begin
      rd32(BDCC_OFS_TIME, v);
      n++;
    end
    chk(v, tn);
    rd32(BDCC_OFS_DATE, v);
    chk(v, dn);
  endtask
  task automatic finish_test;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst   = 1'h1;
    wr    = 1'h0;
    rd    = 1'h0;
    addr  = 8'h0;
    wdata = 32'h0;
    do_reset();
    rd32(BDCC_OFS_PRESC, v);
    chk(v, {9'h0, BDCC_APRE_RST, 1'h0, BDCC_SPRE_RST});
    rd32(BDCC_OFS_DATE, v);
    chk(v, dt(8'h00, 3'h1, 5'h01, 6'h01));
    // back-to-back write and read, then the other words
    bus(1'h1, 1'h0, BDCC_OFS_BKP, bk(0));
    bus(1'h0, 1'h1, BDCC_OFS_BKP, 32'h0);
    bus(1'h0, 1'h0, 8'h0, 32'h0);
    chk(rdata, bk(0));
    for (int i = 1; i < BDCC_BKP_WORDS; i++) begin
      wr32(8'(BDCC_OFS_BKP + 4 * i), bk(i));
    end
    wr32(8'h3C, 32'hFFFF_FFFF);
    rd32(8'h3C, v);
    chk(v, 32'h0);
    rd32(8'(BDCC_OFS_BKP + 4 * BDCC_BKP_WORDS), v);
    chk(v, 32'h0);
    bkp_all();
    do_reset();
    bkp_all();
    // calendar carries, short prescaler
    wr32(BDCC_OFS_PRESC, 32'h1);
    roll(32'h1, 32'h9, dt(8'h24, 3'h1, 5'h01, 6'h01), 32'h10,
         dt(8'h24, 3'h1, 5'h01, 6'h01));
    roll(32'h1, T_LATE, dt(8'h24, 3'h3, 5'h02, 6'h28), 32'h0,
         dt(8'h24, 3'h4, 5'h02, 6'h29));
    roll(32'h1, T_LATE, dt(8'h24, 3'h4, 5'h02, 6'h29), 32'h0,
         dt(8'h24, 3'h5, 5'h03, 6'h01));
    roll(32'h1, T_LATE, dt(8'h23, 3'h3, 5'h02, 6'h28), 32'h0,
         dt(8'h23, 3'h4, 5'h03, 6'h01));
    roll(32'h1, T_LATE, dt(8'h24, 3'h5, 5'h04, 6'h30), 32'h0,
         dt(8'h24, 3'h6, 5'h05, 6'h01));
    roll(32'h1, T_LATE, dt(8'h24, 3'h6, 5'h12, 6'h31), 32'h0,
         dt(8'h25, 3'h7, 5'h01, 6'h01));
    roll(32'h3, T_11, dt(8'h24, 3'h1, 5'h01, 6'h31), T_12PM,
         dt(8'h24, 3'h1, 5'h01, 6'h31));
    rd32(BDCC_OFS_SUBSEC, v);
    chk(v & 32'hFFFF_FFFE, 32'h0);
    // alarm A seconds only, alarm B also needs minute 01
    wr32(BDCC_OFS_CTRL, 32'h0);
    wr32(BDCC_OFS_TIME, 32'h5);
    wr32(BDCC_OFS_ALA, 32'h0E00_0006);
    wr32(BDCC_OFS_ALB, 32'h0C00_0106);
    wr32(BDCC_OFS_MASK, 32'h1);
    wr32(BDCC_OFS_CTRL, 32'h0D);
    wait_irq();
    chk({31'h0, wake}, 32'h1);
    rd32(BDCC_OFS_TIME, v);
    chk(v, 32'h6);
    rd32(BDCC_OFS_STS, v);
    chk(v, 32'h1);
    chk({30'h0, irq, wake}, 32'h0);
    // 00:01:05 then both alarms match on the next second
    wr32(BDCC_OFS_CTRL, 32'h0);
    wr32(BDCC_OFS_TIME, 32'h85);
    wr32(BDCC_OFS_CTRL, 32'h0D);
    wait_irq();
    rd32(BDCC_OFS_STS, v);
    chk(v, 32'h3);
    // wakeup reload 3 at low-speed / 2
    wr32(BDCC_OFS_CTRL, 32'h0);
    wr32(BDCC_OFS_WAKE, 32'h3);
    wr32(BDCC_OFS_MASK, 32'h4);
    wr32(BDCC_OFS_CTRL, 32'h11);
    wait_irq();
    t0 = cyc;
    rd32(BDCC_OFS_STS, v);
    chk(v, 32'h4);
    wait_irq();
    chk_n(cyc - t0, 8 * LS_CLK - 2, 8 * LS_CLK + 2);
    // same reload at low-speed / 4
    wr32(BDCC_OFS_CTRL, 32'h0);
    rd32(BDCC_OFS_STS, v);
    wr32(BDCC_OFS_CTRL, 32'h111);
    wait_irq();
    t0 = cyc;
    rd32(BDCC_OFS_STS, v);
    chk(v, 32'h4);
    wait_irq();
    chk_n(cyc - t0, 16 * LS_CLK - 2, 16 * LS_CLK + 2);
    wr32(BDCC_OFS_CTRL, 32'h0);
    rd32(BDCC_OFS_STS, v);
    // calibration square wave
    wr32(BDCC_OFS_CTRL, 32'h21);
    chk({31'h0, cal_oe}, 32'h1);
    wait_cal();
    t0 = cyc;
    wait_cal();
    chk_n(cyc - t0, BDCC_CAL_DIV * LS_CLK - 2, BDCC_CAL_DIV * LS_CLK + 2);
    wr32(BDCC_OFS_CTRL, 32'h0);
    chk({30'h0, cal_oe, cal_out}, 32'h0);
    finish_test();
  end
endmodule
